// [tb_upstream_isochrony_window0_ctrl.sv]
`timescale 1ns/100ps
module tb_upstream_isochrony_window0_ctrl;
   import uiw_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hot_rst_n = 1'b1;
   logic fund_rst_n = 1'b1;
   logic glob_rst_n = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_be = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic up_req;
   logic [31:0] up_addr;
   logic up_ack;
   logic [TC_W-1:0] up_tc;
   logic [ARB_W-1:0] classic_arb_ctrl = 8'h5a;
   logic [ARB_W-1:0] table_arb_ctrl = 8'ha5;
   logic [ARB_W-1:0] arb_ctrl_eff;
   uiw_arb_mode_t arb_mode;
   logic arb_preempt_en;
   int miscompares = 0;
   int num_checks = 0;
   // classification table: isochrony control, window control, address, expected class
   logic [15:0] iso_v [7] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0001};
   logic [15:0] win_v [7] = '{16'h000b, 16'h000b, 16'h000b, 16'h000b, 16'h000a, 16'h000b, 16'h000f};
   logic [31:0] adr_v [7] = '{32'h1000_0000, 32'h1000_00ff, 32'h0fff_ffff, 32'h1000_0100,
                              32'h1000_0080, 32'h1000_0080, 32'h1000_0080};
   logic [2:0] tc_v [7] = '{3'h5, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7};

   always #25 core_clk = ~core_clk;

   uiw_ctrl i_uiw_ctrl (.core_clk(core_clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n), .fund_rst_n(fund_rst_n),
      .glob_rst_n(glob_rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .up_req(up_req),
      .up_addr(up_addr), .up_ack(up_ack), .up_tc(up_tc), .classic_arb_ctrl(classic_arb_ctrl),
      .table_arb_ctrl(table_arb_ctrl), .arb_ctrl_eff(arb_ctrl_eff), .arb_mode(arb_mode),
      .arb_preempt_en(arb_preempt_en));

   uiw_master_model i_uiw_master_model (.core_clk(core_clk), .up_req(up_req), .up_addr(up_addr));

   // ---------------------------------------------------------------
   // helper tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_be <= be;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data and valid are looked at in the single cycle the valid pulse stands
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rvalid", 32'h1, {31'h0, reg_rvalid});
      chk("reg_rdata", exp, reg_rdata);
   endtask : rd

   // steering follows the registers, so look once the write edge has settled
   task automatic arb(input uiw_arb_mode_t m, input logic [7:0] eff, input logic pre);
      #1;
      chk("arb_mode", 32'(m), 32'(arb_mode));
      chk("arb_ctrl_eff", {24'h0, eff}, {24'h0, arb_ctrl_eff});
      chk("arb_preempt_en", {31'h0, pre}, {31'h0, arb_preempt_en});
   endtask : arb

   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #(4000 * 50);
      miscompares++;
      wrap_up();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values and an unmapped offset
      rd(OFS_ISOCHRONY_CONTROL, 32'h0);
      rd(OFS_WINDOW0_CONTROL, 32'h0);
      rd(OFS_WINDOW0_BASE, 32'h0);
      rd(OFS_WINDOW0_LIMIT, 32'h0);
      rd(8'h14, 32'h0);
      // aggressive bit without table bit is dropped, reserved bits read zero
      wr(OFS_ISOCHRONY_CONTROL, 32'h0000_fffd);
      rd(OFS_ISOCHRONY_CONTROL, 32'h0000_0001);
      arb(UIW_ARB_CLASSIC, 8'h5a, 1'b0);
      wr(OFS_ISOCHRONY_CONTROL, 32'hffff_ffff);
      rd(OFS_ISOCHRONY_CONTROL, 32'h0000_0007);
      arb(UIW_ARB_AGGRESSIVE, 8'ha5, 1'b1);
      wr(OFS_ISOCHRONY_CONTROL, 32'h0000_0003);
      arb(UIW_ARB_TABLE, 8'ha5, 1'b0);
      // control write without lane 0 is ignored
      wr(OFS_ISOCHRONY_CONTROL, 32'h0000_0000, 4'he);
      rd(OFS_ISOCHRONY_CONTROL, 32'h0000_0003);
      wr(OFS_WINDOW0_CONTROL, 32'hffff_fffe);
      rd(OFS_WINDOW0_CONTROL, 32'h0000_000e);
      // scratchpad while the window is disabled, full words and one byte-lane-2 write
      wr(OFS_WINDOW0_BASE, 32'hdead_beef);
      wr(OFS_WINDOW0_BASE, 32'h0012_0000, 4'h4);
      rd(OFS_WINDOW0_BASE, 32'hde12_beef);
      wr(OFS_WINDOW0_BASE, 32'h1000_0000);
      rd(OFS_WINDOW0_BASE, 32'h1000_0000);
      wr(OFS_WINDOW0_LIMIT, 32'h1000_00ff);
      rd(OFS_WINDOW0_LIMIT, 32'h1000_00ff);
      // classification at bounds, disabled window and global disable
      for (int i = 0; i < 7; i++) begin
         wr(OFS_ISOCHRONY_CONTROL, {16'h0, iso_v[i]});
         wr(OFS_WINDOW0_CONTROL, {16'h0, win_v[i]});
         i_uiw_master_model.issue(adr_v[i]);
         #1;
         chk("up_ack", 32'h1, {31'h0, up_ack});
         chk("up_tc", {29'h0, tc_v[i]}, {29'h0, up_tc});
      end
      // each reset source clears the bank
      for (int k = 0; k < 4; k++) begin
         wr(OFS_WINDOW0_BASE, 32'h0000_0001);
         wr(OFS_ISOCHRONY_CONTROL, 32'h0000_0003);
         @(posedge core_clk);
         case (k)
            0: rst_n <= 1'b0;
            1: hot_rst_n <= 1'b0;
            2: fund_rst_n <= 1'b0;
            default: glob_rst_n <= 1'b0;
         endcase
         @(posedge core_clk);
         {rst_n, hot_rst_n, fund_rst_n, glob_rst_n} <= 4'hf;
         rd(OFS_WINDOW0_BASE, 32'h0);
         rd(OFS_ISOCHRONY_CONTROL, 32'h0);
      end
      wrap_up();
   end
endmodule : tb_upstream_isochrony_window0_ctrl

// [uiw_ctrl.sv]
`timescale 1ns/100ps
// Functional notes
// - isochrony control bits 15:3 read zero
// - aggressive bit writable only with table arbitration
// - aggressive bit lets arbiter stop masters midway
// - table bit clear: classic arbiter controls only
// - table bit set: port table drives grants
// - global enable clear forces traffic class zero
// - isochrony control at 04h resets to zero
// - window control at 08h, bits 15:4 zero
// - window class field bits 3:1, reset zero
// - disabled window never affects classification
// - enabled window hit gets window class while global enable is set
// - base register at 0Ch, read/write, reset zero
// - limit register at 10h, read/write, reset zero
// - base/limit are scratchpad while window disabled
// - all four resets clear every register
module uiw_ctrl
   import uiw_pkg::*;
(
   // clock and resets, all synchronous
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hot_rst_n,
   input wire logic fund_rst_n,
   input wire logic glob_rst_n,
   // register access port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_be,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // upstream classification
   input wire logic up_req,
   input wire logic [31:0] up_addr,
   output logic up_ack,
   output logic [TC_W-1:0] up_tc,
   // secondary-bus arbiter steering
   input wire logic [ARB_W-1:0] classic_arb_ctrl,
   input wire logic [ARB_W-1:0] table_arb_ctrl,
   output logic [ARB_W-1:0] arb_ctrl_eff,
   output uiw_arb_mode_t arb_mode,
   output logic arb_preempt_en
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // inclusive range test shared by classification and its checks
   function automatic logic window_hit(input logic [31:0] a, input logic [31:0] lo,
                                       input logic [31:0] hi);
      window_hit = (a >= lo) && (a <= hi);
   endfunction : window_hit

   // byte-lane merge so partial writes keep untouched lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      lane_merge = m;
   endfunction : lane_merge

   // ----------------------------------------------------------------
   // reset and write strobes
   // ----------------------------------------------------------------
   logic clr;
   logic wr_iso;
   logic wr_win;
   logic wr_base;
   logic wr_limit;

   // any of power-on, global, fundamental or hot reset clears the bank
   assign clr = !rst_n || !hot_rst_n || !fund_rst_n || !glob_rst_n;
   assign wr_iso = reg_wr && (reg_addr == OFS_ISOCHRONY_CONTROL) && reg_be[0];
   assign wr_win = reg_wr && (reg_addr == OFS_WINDOW0_CONTROL) && reg_be[0];
   assign wr_base = reg_wr && (reg_addr == OFS_WINDOW0_BASE);
   assign wr_limit = reg_wr && (reg_addr == OFS_WINDOW0_LIMIT);

   // ----------------------------------------------------------------
   // isochrony control
   // ----------------------------------------------------------------
   logic global_isochrony_enable_r;
   logic table_arbitration_enable_r;
   logic aggressive_arbitration_enable_r;

   // only bits 2:0 exist, so upper writes land nowhere
   always_ff @(posedge core_clk) begin
      if (clr) begin
         global_isochrony_enable_r <= ISOCHRONY_CONTROL_RST[ISO_GLOBAL_BIT];
         table_arbitration_enable_r <= ISOCHRONY_CONTROL_RST[ISO_TABLE_BIT];
         aggressive_arbitration_enable_r <= ISOCHRONY_CONTROL_RST[ISO_AGGR_BIT];
      end else if (wr_iso) begin
         global_isochrony_enable_r <= reg_wdata[ISO_GLOBAL_BIT];
         table_arbitration_enable_r <= reg_wdata[ISO_TABLE_BIT];
         // the aggressive bit is dropped whenever table arbitration is left off
         aggressive_arbitration_enable_r <= reg_wdata[ISO_AGGR_BIT] && reg_wdata[ISO_TABLE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // window 0 control, base and limit
   // ----------------------------------------------------------------
   logic window_enable_r;
   logic [TC_W-1:0] window_traffic_class_r;
   logic [31:0] window0_base_r;
   logic [31:0] window0_limit_r;

   // control fields sit wholly in byte lane 0
   always_ff @(posedge core_clk) begin
      if (clr) begin
         window_enable_r <= WINDOW0_CONTROL_RST[WIN_ENABLE_BIT];
         window_traffic_class_r <= WINDOW0_CONTROL_RST[WIN_TC_MSB:WIN_TC_LSB];
      end else if (wr_win) begin
         window_enable_r <= reg_wdata[WIN_ENABLE_BIT];
         window_traffic_class_r <= reg_wdata[WIN_TC_MSB:WIN_TC_LSB];
      end
   end

   // base and limit store freely whatever the window state
   always_ff @(posedge core_clk) begin
      if (clr) begin
         window0_base_r <= WINDOW0_BASE_RST;
         window0_limit_r <= WINDOW0_LIMIT_RST;
      end else begin
         if (wr_base) begin
            window0_base_r <= lane_merge(window0_base_r, reg_wdata, reg_be);
         end
         if (wr_limit) begin
            window0_limit_r <= lane_merge(window0_limit_r, reg_wdata, reg_be);
         end
      end
   end

   // ----------------------------------------------------------------
   // register read path, one cycle after the strobe
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;

   // reserved bits and unmapped offsets return zero
   always_comb begin
      rd_mux = RDATA_UNMAPPED;
      unique case (reg_addr)
         OFS_ISOCHRONY_CONTROL: begin
            rd_mux[ISO_GLOBAL_BIT] = global_isochrony_enable_r;
            rd_mux[ISO_TABLE_BIT] = table_arbitration_enable_r;
            rd_mux[ISO_AGGR_BIT] = aggressive_arbitration_enable_r && table_arbitration_enable_r;
         end
         OFS_WINDOW0_CONTROL: begin
            rd_mux[WIN_ENABLE_BIT] = window_enable_r;
            rd_mux[WIN_TC_MSB:WIN_TC_LSB] = window_traffic_class_r;
         end
         OFS_WINDOW0_BASE: rd_mux = window0_base_r;
         OFS_WINDOW0_LIMIT: rd_mux = window0_limit_r;
         default: rd_mux = RDATA_UNMAPPED;
      endcase
   end

   // data holds until the next read so software can sample late
   always_ff @(posedge core_clk) begin
      if (clr) begin
         reg_rdata <= RDATA_UNMAPPED;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // upstream traffic class mapping
   // ----------------------------------------------------------------
   logic win_apply;

   // a window only counts when both it and the global switch are on
   assign win_apply = global_isochrony_enable_r && window_enable_r
                      && window_hit(up_addr, window0_base_r, window0_limit_r);

   // registered result so the class is stable for the whole ack cycle
   always_ff @(posedge core_clk) begin
      if (clr) begin
         up_ack <= 1'b0;
         up_tc <= TC_DEFAULT;
      end else begin
         up_ack <= up_req;
         if (up_req) begin
            up_tc <= win_apply ? window_traffic_class_r : TC_DEFAULT;
         end
      end
   end

   // ----------------------------------------------------------------
   // arbiter steering
   // ----------------------------------------------------------------
   // classic settings are ignored entirely once the table takes over
   always_comb begin
      if (!table_arbitration_enable_r) begin
         arb_mode = UIW_ARB_CLASSIC;
         arb_ctrl_eff = classic_arb_ctrl;
      end else if (aggressive_arbitration_enable_r) begin
         arb_mode = UIW_ARB_AGGRESSIVE;
         arb_ctrl_eff = table_arb_ctrl;
      end else begin
         arb_mode = UIW_ARB_TABLE;
         arb_ctrl_eff = table_arb_ctrl;
      end
   end

   // mid-transaction stops only in aggressive mode
   assign arb_preempt_en = table_arbitration_enable_r && aggressive_arbitration_enable_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (clr);

   iso_reserved_zero_a: assert property (
      reg_rd && reg_addr == OFS_ISOCHRONY_CONTROL |=> reg_rdata[15:3] == 13'h0000)
      else $error("isochrony reserved bits read nonzero");

   aggr_needs_table_a: assert property (
      reg_rd && reg_addr == OFS_ISOCHRONY_CONTROL && !table_arbitration_enable_r
      |=> !reg_rdata[ISO_AGGR_BIT])
      else $error("aggressive bit read set without table arbitration");

   aggr_preempt_a: assert property (
      wr_iso && reg_wdata[ISO_AGGR_BIT] && reg_wdata[ISO_TABLE_BIT]
      |=> arb_preempt_en && arb_mode == UIW_ARB_AGGRESSIVE)
      else $error("aggressive write did not enable preemption");

   classic_select_a: assert property (
      wr_iso && !reg_wdata[ISO_TABLE_BIT]
      |=> arb_mode == UIW_ARB_CLASSIC && arb_ctrl_eff == classic_arb_ctrl && !arb_preempt_en)
      else $error("classic arbiter not selected");

   table_select_a: assert property (
      table_arbitration_enable_r |-> arb_ctrl_eff == table_arb_ctrl)
      else $error("table arbitration not applied");

   global_off_tc0_a: assert property (
      up_req && !global_isochrony_enable_r |=> up_ack && up_tc == TC_DEFAULT)
      else $error("nonzero class with isochrony disabled");

   win_ctrl_read_a: assert property (
      reg_rd && reg_addr == OFS_WINDOW0_CONTROL
      |=> reg_rdata[31:4] == 28'h0000000 && reg_rdata[3:1] == $past(window_traffic_class_r))
      else $error("window control read mismatch");

   win_hit_class_a: assert property (
      up_req && win_apply |=> up_tc == $past(window_traffic_class_r))
      else $error("window hit got wrong class");

   win_disabled_a: assert property (
      up_req && !window_enable_r |=> up_tc == TC_DEFAULT)
      else $error("disabled window affected class");

   base_store_a: assert property (
      wr_base && reg_be == 4'hf ##1 !wr_base ##1 reg_rd && reg_addr == OFS_WINDOW0_BASE && !wr_base
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("base register did not keep written value");

   limit_store_a: assert property (
      wr_limit && reg_be == 4'hf |=> window0_limit_r == $past(reg_wdata))
      else $error("limit register did not store");

   // ----------------------------------------------------------------
   // checks on reset and on stored fields
   // ----------------------------------------------------------------
   // the reset itself is the trigger here, so the default disable is overridden
   iso_reset_zero_a: assert property (disable iff (1'b0)
      clr |=> global_isochrony_enable_r == ISOCHRONY_CONTROL_RST[ISO_GLOBAL_BIT]
      && table_arbitration_enable_r == ISOCHRONY_CONTROL_RST[ISO_TABLE_BIT]
      && aggressive_arbitration_enable_r == ISOCHRONY_CONTROL_RST[ISO_AGGR_BIT])
      else $error("isochrony control not cleared by reset");

   win_reset_zero_a: assert property (disable iff (1'b0)
      clr |=> window_enable_r == WINDOW0_CONTROL_RST[WIN_ENABLE_BIT]
      && window_traffic_class_r == WINDOW0_CONTROL_RST[WIN_TC_MSB:WIN_TC_LSB])
      else $error("window control not cleared by reset");

   scratch_reset_zero_a: assert property (disable iff (1'b0)
      clr |=> window0_base_r == WINDOW0_BASE_RST && window0_limit_r == WINDOW0_LIMIT_RST)
      else $error("base or limit not cleared by reset");

   // a stale answer surviving a hot reset would be handed to the bus as live
   out_reset_idle_a: assert property (disable iff (1'b0)
      clr |=> !up_ack && !reg_rvalid && up_tc == TC_DEFAULT && reg_rdata == RDATA_UNMAPPED)
      else $error("outputs not idle after reset");

   win_ctrl_store_a: assert property (
      wr_win |=> window_traffic_class_r == $past(reg_wdata[WIN_TC_MSB:WIN_TC_LSB])
      && window_enable_r == $past(reg_wdata[WIN_ENABLE_BIT]))
      else $error("window control write not stored");

   base_store_full_a: assert property (
      wr_base && reg_be == 4'hf |=> window0_base_r == $past(reg_wdata))
      else $error("base register did not store");

   aggr_clear_follow_a: assert property (
      wr_iso && !reg_wdata[ISO_TABLE_BIT] |=> !aggressive_arbitration_enable_r && !arb_preempt_en)
      else $error("aggressive bit survived table arbitration off");

   classic_only_a: assert property (
      !table_arbitration_enable_r |-> arb_mode == UIW_ARB_CLASSIC && arb_ctrl_eff == classic_arb_ctrl)
      else $error("classic settings not in charge");

   table_no_preempt_a: assert property (
      table_arbitration_enable_r && !aggressive_arbitration_enable_r
      |-> arb_mode == UIW_ARB_TABLE && !arb_preempt_en)
      else $error("table mode preempts or wrong mode");

   preempt_aggr_only_a: assert property (
      arb_preempt_en |-> arb_mode == UIW_ARB_AGGRESSIVE && table_arbitration_enable_r)
      else $error("preemption outside aggressive mode");

   // bounds are tested apart from the shared hit function so a slip there shows
   win_bound_hit_a: assert property (
      up_req && global_isochrony_enable_r && window_enable_r
      && up_addr >= window0_base_r && up_addr <= window0_limit_r
      |=> up_tc == $past(window_traffic_class_r))
      else $error("address inside window got wrong class");

   win_miss_tc0_a: assert property (
      up_req && (up_addr < window0_base_r || up_addr > window0_limit_r) |=> up_tc == TC_DEFAULT)
      else $error("address outside window got nonzero class");

   ack_follows_req_a: assert property (
      up_req |=> up_ack)
      else $error("classify request not acknowledged");

   iso_upper_zero_a: assert property (
      reg_rd && reg_addr == OFS_ISOCHRONY_CONTROL |=> reg_rdata[31:16] == 16'h0000)
      else $error("isochrony upper half read nonzero");

endmodule : uiw_ctrl

// [uiw_master_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// secondary bus master issuing upstream classify requests
// ---------------------------------------------------------------
module uiw_master_model (
   // clock
   input wire logic core_clk,
   // upstream request side
   output logic up_req,
   output logic [31:0] up_addr
);
   // idle values at time zero
   initial begin
      up_req = 1'b0;
      up_addr = 32'h0000_0000;
   end

   // one request cycle; the address is inverted once released so a stale value cannot pass for a live one
   task automatic issue(input logic [31:0] a);
      @(posedge core_clk);
      up_req <= 1'b1;
      up_addr <= a;
      @(posedge core_clk);
      up_req <= 1'b0;
      up_addr <= ~a;
   endtask : issue
endmodule : uiw_master_model

// [uiw_pkg.sv]
package uiw_pkg;
   // ----------------------------------------------------------------
   // register map, byte addresses inside the device control window
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_ISOCHRONY_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_WINDOW0_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_WINDOW0_BASE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_WINDOW0_LIMIT = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ISO_GLOBAL_BIT = 0;
   localparam int ISO_TABLE_BIT = 1;
   localparam int ISO_AGGR_BIT = 2;
   localparam int WIN_ENABLE_BIT = 0;
   localparam int WIN_TC_LSB = 1;
   localparam int WIN_TC_MSB = 3;
   localparam int TC_W = 3;
   localparam int ARB_W = 8;

   // ----------------------------------------------------------------
   // reset values and defaults
   // ----------------------------------------------------------------
   localparam logic [15:0] ISOCHRONY_CONTROL_RST = 16'h0000;
   localparam logic [15:0] WINDOW0_CONTROL_RST = 16'h0000;
   localparam logic [31:0] WINDOW0_BASE_RST = 32'h0000_0000;
   localparam logic [31:0] WINDOW0_LIMIT_RST = 32'h0000_0000;
   localparam logic [TC_W-1:0] TC_DEFAULT = 3'h0;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   // arbiter source selection seen by the secondary-bus arbiter
   typedef enum logic [1:0] {
      UIW_ARB_CLASSIC,
      UIW_ARB_TABLE,
      UIW_ARB_AGGRESSIVE
   } uiw_arb_mode_t;
endpackage : uiw_pkg
